// ===== rtl/valve_reference_selector.v
// Purpose: Picks the valve set-point from stored values or analog input.
// Assumes: APB slave on pclk; analog samples come from same-clock logic.
// Notes: Drive outputs are unsigned current commands per solenoid.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "valve_ref_defs.vh"
module valve_reference_selector #(
    parameter dual_solenoid_variant = 1'b1 // Two-solenoid driver build
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Pins from the machine control unit
    input wire profile_select_in_1,
    input wire profile_select_in_2,
    input wire profile_select_in_3,
    input wire profile_select_in_4,
    input wire driver_enable_in,
    // Analog samples, signed, same clock
    input wire [15:0] flow_ref_analog_in,
    input wire [15:0] pressure_feedback_in,
    // Fault from the current stage, same clock
    input wire current_fault_in,
    // Current commands and status pin
    output wire [15:0] solenoid_a_drive,
    output wire [15:0] solenoid_b_drive,
    output wire status_out
);
    // Software state
    reg [31:0] ctrl_q; // Mode bits and status function
    reg [31:0] power_limit_setting; // Maximum p x Q
    reg [31:0] tbl_q [0:14]; // Stored set-points with ramp times
    reg [31:0] prdata_q; // Read data, loaded in setup
    reg pslverr_q; // Unmapped address or status write seen in setup
    // Output state
    reg [15:0] drive_a_q; // Solenoid A command
    reg [15:0] drive_b_q; // Solenoid B command
    reg status_q; // Status pin
    reg [15:0] flow_q; // Regulated flow after limiting
    reg limit_q; // Limiter is clamping
    // Synchronised pins
    wire [4:0] pins;
    wire [3:0] sel; // Select inputs, bit 0 is input 1
    wire enabled; // Driver enable level
    // Decode results
    reg hit_a; // Channel A has a stored value picked
    reg hit_b; // Channel B has a stored value picked
    reg [3:0] idx_a; // Entry for channel A
    reg [3:0] idx_b; // Entry for channel B
    // Mode bits
    wire int_en;
    wire binary;
    wire split;
    wire plim_on;
    wire [1:0] stsel;
    // Ramp targets and results
    wire use_a; // Channel A follows the table
    wire use_b; // Channel B follows the table
    wire [15:0] tgt_a;
    wire [15:0] tgt_b;
    wire [15:0] ramp_a;
    wire [15:0] ramp_b;
    // Limiter arithmetic
    wire [31:0] quotient;
    wire [15:0] flow_mag;
    wire flow_pos;
    wire press_pos;
    // APB decode
    wire setup;
    wire wr_access;
    wire in_table;
    wire [3:0] tbl_idx;
    integer k;

    assign int_en = ctrl_q[`CTRL_INT_EN];
    assign binary = ctrl_q[`CTRL_BINARY];
    assign split = ctrl_q[`CTRL_SPLIT] & dual_solenoid_variant;
    assign plim_on = ctrl_q[`CTRL_PLIM_EN] & dual_solenoid_variant;
    assign stsel = ctrl_q[`CTRL_STSEL_HI:`CTRL_STSEL_LO];

    // Select and enable pins cross into pclk before any decode
    select_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in({driver_enable_in, profile_select_in_4, profile_select_in_3,
                 profile_select_in_2, profile_select_in_1}),
        .pin_sync(pins)
    );
    assign sel = pins[3:0];
    assign enabled = pins[4];

    // Select decode; lowest input wins in standard mode if several are high
    always @* begin
        hit_a = 1'b0;
        hit_b = 1'b0;
        idx_a = 4'h0;
        idx_b = 4'h0;
        if (binary && !split) begin
            // Every nonzero code is its own entry
            hit_a = (sel != 4'h0);
            idx_a = sel - 4'h1;
        end else if (binary) begin
            // Two bits per channel, three codes each
            hit_a = (sel[1:0] != 2'b00);
            idx_a = {2'b00, sel[1:0]} - 4'h1;
            hit_b = (sel[3:2] != 2'b00);
            idx_b = {2'b00, sel[3:2]} + 4'h2;
        end else if (!split) begin
            // One input per entry
            hit_a = (sel != 4'h0);
            if (sel[0]) begin
                idx_a = 4'h0;
            end else if (sel[1]) begin
                idx_a = 4'h1;
            end else if (sel[2]) begin
                idx_a = 4'h2;
            end else begin
                idx_a = 4'h3;
            end
        end else begin
            // Inputs 1,2 for channel A, inputs 3,4 for channel B
            hit_a = sel[0] | sel[1];
            idx_a = sel[0] ? 4'h0 : 4'h1;
            hit_b = sel[2] | sel[3];
            idx_b = sel[2] ? 4'h2 : 4'h3;
        end
    end

    // Table only when int_en is set and an input of that channel is high, else analog path
    assign use_a = int_en & hit_a;
    assign use_b = int_en & hit_b;
    assign tgt_a = use_a ? tbl_q[idx_a][`ENT_VAL_HI:0]
                         : flow_ref_analog_in;
    assign tgt_b = use_b ? tbl_q[idx_b][`ENT_VAL_HI:0]
                         : flow_ref_analog_in;

    // Each channel ramps with the ramp time of its picked entry
    ramp_slew u_ramp_a (
        .pclk(pclk),
        .presetn(presetn),
        .target(tgt_a),
        .rate(tbl_q[idx_a][31:`ENT_RATE_LO]),
        .bypass(~use_a),
        .value(ramp_a)
    );
    ramp_slew u_ramp_b (
        .pclk(pclk),
        .presetn(presetn),
        .target(tgt_b),
        .rate(tbl_q[idx_b][31:`ENT_RATE_LO]),
        .bypass(~use_b),
        .value(ramp_b)
    );

    // Limiter operands; a wide divider costs area but keeps one-cycle latency
    assign flow_pos = ~ramp_a[15] & (ramp_a != 16'h0000);
    assign flow_mag = ramp_a;
    assign press_pos = ~pressure_feedback_in[15] &
                       (pressure_feedback_in != 16'h0000);
    assign quotient = press_pos ?
        power_limit_setting / {16'h0000, pressure_feedback_in} :
        32'hFFFF_FFFF;

    // Regulated flow: clamp positive flow to limit over pressure
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flow_q <= 16'h0000;
            limit_q <= 1'b0;
        end else if (plim_on && flow_pos &&
                     quotient < {16'h0000, flow_mag}) begin
            flow_q <= quotient[15:0];
            limit_q <= 1'b1;
        end else begin
            flow_q <= ramp_a;
            limit_q <= 1'b0;
        end
    end

    // Solenoid commands, zero while the driver is disabled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_a_q <= 16'h0000;
            drive_b_q <= 16'h0000;
        end else if (!enabled) begin
            drive_a_q <= 16'h0000;
            drive_b_q <= 16'h0000;
        end else if (split) begin
            // Two single-solenoid valves, positive part only
            drive_a_q <= flow_q[15] ? 16'h0000 : flow_q;
            drive_b_q <= ramp_b[15] ? 16'h0000 : ramp_b;
        end else begin
            // One double-solenoid valve: sign picks the coil
            drive_a_q <= flow_q[15] ? 16'h0000 : flow_q;
            drive_b_q <= flow_q[15] ? (16'h0000 - flow_q) : 16'h0000;
        end
    end

    // Status pin function, fault after reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 1'b0;
        end else begin
            case (stsel)
                `STSEL_FAULT: status_q <= current_fault_in;
                `STSEL_ENABLED: status_q <= enabled;
                `STSEL_LIMIT: status_q <= limit_q;
                `STSEL_INTREF: status_q <= use_a | use_b;
                default: status_q <= current_fault_in;
            endcase
        end
    end

    // APB decode; the slave never waits, so pready is tied high
    assign setup = psel & ~penable;
    assign wr_access = psel & penable & pwrite;
    assign in_table = (paddr >= `OFS_TABLE) && (paddr <= `TABLE_LAST) &&
                      (paddr[1:0] == 2'b00);
    assign tbl_idx = paddr[5:2];

    // Control and limit registers written at the access edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CTRL_RESET;
            power_limit_setting <= `POWER_RESET;
        end else if (wr_access && !pslverr_q) begin
            if (paddr == `OFS_CTRL) begin
                ctrl_q <= {26'h000_0000, pwdata[5:0]};
            end
            if (paddr == `OFS_POWER) begin
                power_limit_setting <= pwdata;
            end
        end
    end

    // Table entries, one flop word per stored value
    genvar e;
    generate
        for (e = 0; e < `TABLE_N; e = e + 1) begin : g_ent
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tbl_q[e] <= `ENTRY_RESET;
                end else if (wr_access && in_table && tbl_idx == e) begin
                    tbl_q[e] <= pwdata;
                end
            end
        end
    endgenerate

    // Read data and error caught in setup, presented in access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            if (paddr == `OFS_CTRL) begin
                prdata_q <= ctrl_q;
            end else if (paddr == `OFS_POWER) begin
                prdata_q <= power_limit_setting;
            end else if (paddr == `OFS_STATUS) begin
                if (pwrite) begin
                    pslverr_q <= 1'b1; // Status is read-only
                end
                prdata_q <= {enabled, limit_q, use_b, use_a, sel,
                             idx_b, idx_a, flow_q};
            end else if (in_table) begin
                for (k = 0; k < `TABLE_N; k = k + 1) begin
                    if (tbl_idx == k) begin
                        prdata_q <= tbl_q[k];
                    end
                end
            end else begin
                pslverr_q <= 1'b1; // Unmapped word
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & pslverr_q;
    assign solenoid_a_drive = drive_a_q;
    assign solenoid_b_drive = drive_b_q;
    assign status_out = status_q;
endmodule // valve_reference_selector
`default_nettype wire

// ===== rtl/valve_ref_defs.vh
// Purpose: Offsets, field positions and reset values of the selector.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes: Included by bare name; definitions only.
`ifndef VALVE_REF_DEFS_VH
`define VALVE_REF_DEFS_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_POWER 8'h04
`define OFS_STATUS 8'h08
`define OFS_TABLE 8'h40
`define TABLE_LAST 8'h78

// Control register fields
`define CTRL_INT_EN 0
`define CTRL_BINARY 1
`define CTRL_SPLIT 2
`define CTRL_PLIM_EN 3
`define CTRL_STSEL_LO 4
`define CTRL_STSEL_HI 5

// Status output functions
`define STSEL_FAULT 2'h0
`define STSEL_ENABLED 2'h1
`define STSEL_LIMIT 2'h2
`define STSEL_INTREF 2'h3

// Table entry fields: set-point low half, ramp time high half
`define ENT_VAL_HI 15
`define ENT_RATE_LO 16

// Reset values
`define CTRL_RESET 32'h0000_0000
`define POWER_RESET 32'hFFFF_FFFF
`define ENTRY_RESET 32'h0000_0000

// Table size
`define TABLE_N 15

`endif

// ===== rtl/select_sync.v
// Purpose: Two-flop synchroniser for the four select pins and enable.
// Assumes: Pins are asynchronous to pclk.
// Notes: First stage is read only by the second stage.
`timescale 1ns/100ps
`default_nettype none
module select_sync (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Raw pins
    input wire [4:0] pin_in,
    // Synchronised levels
    output wire [4:0] pin_sync
);
    reg [4:0] meta_q; // First stage, metastability catcher
    reg [4:0] sync_q; // Second stage, safe to decode
    genvar i;
    // One pair of flops per pin
    generate
        for (i = 0; i < 5; i = i + 1) begin : g_bit
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= pin_in[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate
    assign pin_sync = sync_q;
endmodule // select_sync
`default_nettype wire

// ===== rtl/ramp_slew.v
// Purpose: Moves a set-point one LSB at a time toward its target.
// Assumes: rate is pclk cycles per LSB step; zero means a direct jump.
// Notes: Bypass follows the target at once, used for the analog path.
`timescale 1ns/100ps
`default_nettype none
module ramp_slew (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Target and timing
    input wire [15:0] target,
    input wire [15:0] rate,
    input wire bypass,
    // Present set-point, signed
    output wire [15:0] value
);
    reg [15:0] value_q; // Present set-point
    reg [15:0] cnt_q; // Cycles since the last step
    wire at_target; // Nothing left to move
    wire step_now; // Step interval elapsed
    assign at_target = (value_q == target);
    assign step_now = (cnt_q >= rate - 16'h0001);
    // Slew: signed compare decides the step direction
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= 16'h0000;
            cnt_q <= 16'h0000;
        end else if (bypass || rate == 16'h0000) begin
            value_q <= target;
            cnt_q <= 16'h0000;
        end else if (at_target) begin
            cnt_q <= 16'h0000;
        end else if (step_now) begin
            cnt_q <= 16'h0000;
            if ($signed(target) > $signed(value_q)) begin
                value_q <= value_q + 16'h0001;
            end else begin
                value_q <= value_q - 16'h0001;
            end
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    assign value = value_q;
endmodule // ramp_slew
`default_nettype wire

// ===== dv/valve_ref_checker_sva.sv
// Purpose: Port-level checks of the valve reference selector.
// Assumes: Shadows CTRL and POWER from APB writes seen at the ports.
// Notes: Windows of 3-8 cycles cover the 2-flop sync and output registers.
`timescale 1ns/100ps
`default_nettype none
`include "valve_ref_defs.vh"
module valve_ref_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // Pins and samples
    input wire logic profile_select_in_1,
    input wire logic profile_select_in_2,
    input wire logic profile_select_in_3,
    input wire logic profile_select_in_4,
    input wire logic driver_enable_in,
    input wire logic [15:0] flow_ref_analog_in,
    input wire logic [15:0] pressure_feedback_in,
    input wire logic current_fault_in,
    // Outputs watched
    input wire logic [15:0] solenoid_a_drive,
    input wire logic [15:0] solenoid_b_drive,
    input wire logic status_out
);
    logic [31:0] ctrl_q; // Shadow of the control word
    logic [31:0] power_q; // Shadow of the power limit
    logic [31:0] quot; // Limit divided by pressure
    logic [15:0] lim_f; // Expected limited flow
    logic sel_low; // No select pin high
    logic plain; // Analog path, no split
    wire signed [15:0] an = flow_ref_analog_in;
    assign quot = power_q / {16'h0000, pressure_feedback_in};
    assign lim_f = (quot < {16'h0000, an}) ? quot[15:0] : an;
    assign sel_low = !(profile_select_in_1 | profile_select_in_2 |
        profile_select_in_3 | profile_select_in_4);
    // Steadiness of the analog sample is judged inside each property
    assign plain = !ctrl_q[`CTRL_SPLIT] && driver_enable_in &&
        (!ctrl_q[`CTRL_INT_EN] || sel_low);
    // Shadow registers follow writes at the access edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CTRL_RESET;
            power_q <= `POWER_RESET;
        end else if (psel && penable && pwrite) begin
            if (paddr == `OFS_CTRL) ctrl_q <= pwdata;
            if (paddr == `OFS_POWER) power_q <= pwdata;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_analog_path: assert property ((plain
        && !ctrl_q[`CTRL_PLIM_EN] && $stable(flow_ref_analog_in))[*6]
        |-> solenoid_a_drive == (an[15] ? 16'h0000 : an) &&
        solenoid_b_drive == (an[15] ? 16'(-an) : 16'h0000))
        else $error("analog path drive wrong");
    a_power_limit: assert property ((plain && ctrl_q[`CTRL_PLIM_EN]
        && an > 0 && $stable(flow_ref_analog_in)
        && $signed(pressure_feedback_in) > 0 && $stable(quot))[*6]
        |-> solenoid_a_drive == lim_f) else $error("limited flow wrong");
    a_pressure_zero: assert property ((plain && ctrl_q[`CTRL_PLIM_EN]
        && an > 0 && $stable(flow_ref_analog_in)
        && $signed(pressure_feedback_in) <= 0)[*6]
        |-> solenoid_a_drive == an) else $error("flow limited at zero pressure");
    a_disabled_zero: assert property ((!driver_enable_in)[*8]
        |-> solenoid_a_drive == 16'h0000 && solenoid_b_drive == 16'h0000)
        else $error("drive while disabled");
    a_status_fault: assert property ((ctrl_q[5:4] == `STSEL_FAULT
        && $stable(current_fault_in))[*3] |-> status_out == current_fault_in)
        else $error("status not showing fault");
    a_status_enabled: assert property ((ctrl_q[5:4] == `STSEL_ENABLED
        && driver_enable_in)[*5] |-> status_out) else $error("status not enabled");
    a_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    a_status_ro: assert property (psel && penable && pwrite
        && paddr == `OFS_STATUS |-> pslverr) else $error("status write accepted");
endmodule // valve_ref_checker
bind valve_reference_selector valve_ref_checker valve_ref_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .profile_select_in_1(profile_select_in_1),
    .profile_select_in_2(profile_select_in_2),
    .profile_select_in_3(profile_select_in_3),
    .profile_select_in_4(profile_select_in_4),
    .driver_enable_in(driver_enable_in),
    .flow_ref_analog_in(flow_ref_analog_in),
    .pressure_feedback_in(pressure_feedback_in),
    .current_fault_in(current_fault_in), .solenoid_a_drive(solenoid_a_drive),
    .solenoid_b_drive(solenoid_b_drive), .status_out(status_out));
`default_nettype wire

// ===== dv/mcu_pins_model.sv
// Purpose: Machine control unit that drives select and enable pins.
// Assumes: Requests come from the bench; pins change after a clock edge.
// Notes: Levels only; the unit never glitches a pin between requests.
`timescale 1ns/100ps
`default_nettype none
module mcu_pins_model (
    // Clock
    input wire logic pclk,
    // Requests
    input wire logic [3:0] sel_req,
    input wire logic en_req,
    // Pins
    output var logic [3:0] sel_pins,
    output var logic en_pin
);
    // Pins start low so the driver sees a disabled, unselected unit
    initial begin
        sel_pins = 4'h0;
        en_pin = 1'b0;
    end
    // Four select levels and the enable level follow the request
    always @(posedge pclk) begin
        sel_pins <= sel_req;
        en_pin <= en_req;
    end
endmodule // mcu_pins_model
`default_nettype wire

// ===== dv/valve_reference_selector_test.sv
// Purpose: Self-checking bench for the valve reference selector.
// Assumes: Zero-wait APB slave; drive follows a pin change within 5 edges.
// Notes: Random analog values and table entries from a fixed seed.
`timescale 1ns/100ps
`default_nettype none
`include "valve_ref_defs.vh"
module valve_reference_selector_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, en_req = 0, fault = 0, en_pin, er;
    logic [3:0] sel_req = 0, sel_pins;
    logic [15:0] flow = 0, press = 0, drv_a, drv_b, tbl [15];
    logic [15:0] fv, pv; // Values about to be driven, known before the edge
    logic status_out;
    integer err_count = 0, comparisons = 0, seed = 32'hc328, i;
    // 25 MHz clock
    always #20 pclk = ~pclk;
    valve_reference_selector valve_reference_selector_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .profile_select_in_1(sel_pins[0]),
        .profile_select_in_2(sel_pins[1]), .profile_select_in_3(sel_pins[2]),
        .profile_select_in_4(sel_pins[3]), .driver_enable_in(en_pin),
        .flow_ref_analog_in(flow), .pressure_feedback_in(press),
        .current_fault_in(fault), .solenoid_a_drive(drv_a),
        .solenoid_b_drive(drv_b), .status_out(status_out));
    mcu_pins_model mcu_pins_model_inst (.pclk(pclk), .sel_req(sel_req),
        .en_req(en_req), .sel_pins(sel_pins), .en_pin(en_pin));
    // Expected coil pair for a nonsplit signed flow
    function automatic [31:0] pair(input [15:0] f);
        pair = f[15] ? {16'h0000, 16'(-f)} : {f, 16'h0000};
    endfunction
    // Expected limited flow for a limit of 1000
    function automatic [15:0] lim(input [15:0] p, input [15:0] f);
        lim = (p == 0 || 32'd1000 / p >= f) ? f : 16'(32'd1000 / p);
    endfunction
    task automatic chk(input [31:0] got, input [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input w, input [7:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Read and compare data and error flag
    task automatic rchk(input [7:0] a, input [31:0] exp, input exp_e);
        apb(0, a, 0);
        chk(rd, exp);
        chk(er, exp_e);
    endtask
    task automatic pick(input [3:0] s, input [31:0] exp);
        sel_req <= s;
        repeat (8) @(posedge pclk);
        chk({drv_a, drv_b}, exp);
    endtask
    task automatic print_verdict;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        print_verdict;
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        rchk(`OFS_CTRL, `CTRL_RESET, 0);
        rchk(`OFS_POWER, `POWER_RESET, 0);
        rchk(`OFS_TABLE, `ENTRY_RESET, 0);
        rchk(8'h0C, 0, 1);
        apb(1, `OFS_STATUS, 1);
        chk(er, 1);
        fault <= 1; en_req <= 1;
        pick(0, 0);
        chk(status_out, 1);
        // Analog path, internal off then on with no pin high
        for (i = 0; i < 16; i++) begin
            apb(1, `OFS_CTRL, i & 1);
            fv = (i == 0) ? 16'h8001 : 16'($random(seed));
            flow <= fv;
            pick(0, pair(fv));
        end
        for (i = 0; i < `TABLE_N; i++) begin
            tbl[i] = 16'($random(seed)) & 16'h7FFF | 16'h0001;
            apb(1, `OFS_TABLE + 8'(4 * i), {16'h0000, tbl[i]});
            rchk(`OFS_TABLE + 8'(4 * i), {16'h0000, tbl[i]}, 0);
        end
        apb(1, `OFS_CTRL, 1);
        for (i = 0; i < 4; i++) pick(4'(1 << i), pair(tbl[i]));
        pick(4'b1010, pair(tbl[1]));
        apb(1, `OFS_CTRL, 3);
        for (i = 1; i < 16; i++) pick(4'(i), pair(tbl[i - 1]));
        apb(1, `OFS_CTRL, 5);
        pick(4'b0110, {tbl[1], tbl[2]});
        apb(1, `OFS_CTRL, 7);
        pick(4'b0111, {tbl[2], tbl[3]});
        apb(1, `OFS_CTRL, 1);
        apb(1, `OFS_TABLE, 32'h0000_FED4);
        pick(1, pair(16'hFED4));
        // Slow ramp: 40 steps of 4 cycles each
        flow <= 0;
        pick(0, 0);
        apb(1, `OFS_TABLE + 8'h04, 32'h0004_0028);
        pick(2, 0);
        repeat (50) @(posedge pclk);
        chk(drv_a > 0 && drv_a < 40, 1);
        repeat (150) @(posedge pclk);
        chk(drv_a, 40);
        en_req <= 0;
        pick(2, 0);
        apb(1, `OFS_CTRL, 32'h0000_0010);
        fault <= 0;
        en_req <= 1;
        pick(0, 0);
        chk(status_out, 1);
        // Power limit with limit 1000, status pin shows limiting
        apb(1, `OFS_CTRL, 32'h0000_0028);
        apb(1, `OFS_POWER, 1000);
        for (i = 0; i < 12; i++) begin
            pv = (i == 0) ? 16'd20 : 16'($random(seed)) & 16'h00FF;
            fv = (i == 0) ? 16'd100 : 16'($random(seed)) & 16'h0FFF;
            press <= pv;
            flow <= fv;
            pick(0, {lim(pv, fv), 16'h0000});
            chk(status_out, lim(pv, fv) != fv);
        end
        print_verdict;
    end
endmodule // valve_reference_selector_test
`default_nettype wire
